/* shared/scsa_regs.svh */
/*
  Constants of the serial management access block: frame fields, register
  offsets, flag bit positions and reset values.
  Assumes inclusion by bare name from the package; the design modules use its macros through it.
*/
// How it works
// R1: Host opens each frame with at least 32 ones, then start pattern 01.
// R2: Read frames carry opcode 10; no write opcode exists for table access.
// R3: One table-select bit follows: 1 picks counter table, 0 picks EEPROM image.
// R4: Host then shifts in a seven-bit target register address.
// R5: After turnaround the device returns exactly 32 data bits per read.
// R6: Counter data leaves most significant bit first, bit 31 down to bit 0.
// R7: EEPROM reads build the 32-bit word from two adjacent EEPROM registers.
// R8: Even address sends address+1 then address; odd sends address then address-1.
// R9: Host supplies at least one serial clock during idle after each frame.
// R10: Host holds select low for the whole frame; clock and data act like MDC/MDIO.
// R11: Counter-clear frames carry opcode 01 after the same preamble and start.
// R12: Clear frames carry a two-bit device address; act only on strap match.
// R13: Clear-scope 1 clears all counters of a port; 0 clears one counter.
// R14: After the scope bit the host sends a port number or counter index.
// R15: Cable status holds a two-bit length and broken flag for ports 0 to 4.
// R16: Receive packet or byte counter overflow sets a sticky flag, ports 0 to 5.
// R17: Transmit packet or byte counter overflow sets a sticky flag, ports 0 to 5.
// R18: Collision or error counter overflow sets a sticky flag, ports 0 to 5.
// R19: Output data changes after the serial clock falls, sampled on next rise.
// R20: Turnaround lasts two clocks; device drives only after it ends.
// R21: Reserved bits read zero; all status and flag registers reset to zero.
`ifndef SCSA_REGS_SVH
`define SCSA_REGS_SVH

// Frame layout.
`define SCSA_PRE_MIN 6'h20
`define SCSA_OP_READ 2'h2
`define SCSA_OP_CLEAR 2'h1
`define SCSA_OP_LAST 6'h01
`define SCSA_RD_HDR_LAST 6'h07
`define SCSA_CLR_HDR_LAST 6'h09
`define SCSA_TA_LAST 6'h01
`define SCSA_DATA_BITS 6'h20

// Register offsets inside the counter table.
`define SCSA_OFS_CABLE 7'h03
`define SCSA_OFS_RX_OVF 7'h3a
`define SCSA_OFS_TX_OVF 7'h3b
`define SCSA_OFS_CE_OVF 7'h3c
`define SCSA_REG_RESET 32'h0000_0000

// Cable status: base bit of each port's length field, flag sits two above.
`define SCSA_CAB_P0 5'h00
`define SCSA_CAB_P1 5'h06
`define SCSA_CAB_P2 5'h0c
`define SCSA_CAB_P3 5'h12
`define SCSA_CAB_P4 5'h15
`define SCSA_CAB_FLAG_OFS 5'h02

// Overflow flags: low-group bit per port, high group sits nine above.
`define SCSA_OVF_P0 5'h00
`define SCSA_OVF_P1 5'h02
`define SCSA_OVF_P2 5'h04
`define SCSA_OVF_P3 5'h06
`define SCSA_OVF_P4 5'h07
`define SCSA_OVF_P5 5'h08
`define SCSA_OVF_HI_OFS 5'h09

`endif

/* shared/scsa_pkg.sv */
/*
  Types of the serial management access block: frame states and the
  packed carriers for overflow events and clear requests.
  Assumes scsa_regs.svh is on the include path.
*/
package scsa_pkg;
  `include "scsa_regs.svh"

  typedef enum logic [2:0] {
    ST_PRE, ST_START, ST_OP, ST_HDR, ST_TA, ST_DATA
  } scsa_state_type;

  // One-cycle overflow pulses, one bit per port 0..5.
  typedef struct packed {
    logic [5:0] rx_pkt;
    logic [5:0] rx_byte;
    logic [5:0] tx_pkt;
    logic [5:0] tx_byte;
    logic [5:0] col;
    logic [5:0] err;
  } scsa_ovf_type;

  // Clear request toward the counter store.
  typedef struct packed {
    logic port;
    logic counter;
    logic [6:0] index;
  } scsa_clear_type;
endpackage : scsa_pkg

/* core/scsa_sync.sv */
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to CLK_I and change slowly.
*/
`timescale 1ns/1ps
module scsa_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Pin side and synchronised side.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : scsa_sync

/* core/scsa_top.sv */
/*
  Serial management access path: decodes read and counter-clear frames from
  the host, returns counter-table or EEPROM-image words, and holds the cable
  status and counter overflow flag registers.
  Assumes the counter store and EEPROM image answer reads combinationally on
  CLK_I, and that the serial clock is far slower than CLK_I.
*/
`timescale 1ns/1ps
module scsa_top
  import scsa_pkg::*;
(
  // System clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Serial management pins.
  input wire logic SERIAL_MGMT_CLOCK_I,
  input wire logic SERIAL_MGMT_SELECT_N_I,
  input wire logic SERIAL_MGMT_DATA_I,
  output logic SERIAL_MGMT_DATA_O,
  output logic SERIAL_MGMT_DATA_OE_O,
  input wire logic [1:0] CHIP_PHYS_ADDR_STRAP_I,
  // Counter table read port.
  output logic [6:0] CNT_RD_ADDR_O,
  input wire logic [31:0] CNT_RD_DATA_I,
  // EEPROM image read ports, high half and low half of the word.
  output logic [6:0] EE_HI_ADDR_O,
  input wire logic [15:0] EE_HI_DATA_I,
  output logic [6:0] EE_LO_ADDR_O,
  input wire logic [15:0] EE_LO_DATA_I,
  // Status sources from the port logic.
  input wire logic [9:0] CABLE_FAULT_LEN_I,
  input wire logic [4:0] CABLE_BROKEN_I,
  input wire scsa_ovf_type OVF_EVENT_I,
  // Clear requests toward the counter store.
  output scsa_clear_type CLEAR_O
);

  // Base bit of a port's cable field.
  function automatic logic [4:0] cab_base(input int unsigned p);
    unique case (p)
      0: cab_base = `SCSA_CAB_P0;
      1: cab_base = `SCSA_CAB_P1;
      2: cab_base = `SCSA_CAB_P2;
      3: cab_base = `SCSA_CAB_P3;
      default: cab_base = `SCSA_CAB_P4;
    endcase
  endfunction : cab_base

  // Low-group flag bit of a port in the overflow registers.
  function automatic logic [4:0] ovf_pos(input logic [2:0] p);
    unique case (p)
      3'h0: ovf_pos = `SCSA_OVF_P0;
      3'h1: ovf_pos = `SCSA_OVF_P1;
      3'h2: ovf_pos = `SCSA_OVF_P2;
      3'h3: ovf_pos = `SCSA_OVF_P3;
      3'h4: ovf_pos = `SCSA_OVF_P4;
      default: ovf_pos = `SCSA_OVF_P5;
    endcase
  endfunction : ovf_pos

  // Sticky set pattern for a pair of event groups.
  function automatic logic [31:0] ovf_set(input logic [5:0] lo, input logic [5:0] hi);
    logic [31:0] v;
    v = `SCSA_REG_RESET;
    for (int p = 0; p < 6; p++) begin
      v[ovf_pos(3'(p))] = lo[p];
      v[ovf_pos(3'(p)) + `SCSA_OVF_HI_OFS] = hi[p];
    end
    return v;
  endfunction : ovf_set

  // Both flag bits that belong to one port; ports above 5 match none.
  function automatic logic [31:0] port_mask(input logic [6:0] port);
    logic [31:0] v;
    v = `SCSA_REG_RESET;
    if (port < 7'h06) begin
      v[ovf_pos(port[2:0])] = 1'b1;
      v[ovf_pos(port[2:0]) + `SCSA_OVF_HI_OFS] = 1'b1;
    end
    return v;
  endfunction : port_mask

  // Pin synchronisation.
  logic [4:0] pins_sync;
  scsa_sync #(.WIDTH(5)) u_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .async_i({CHIP_PHYS_ADDR_STRAP_I, SERIAL_MGMT_SELECT_N_I, SERIAL_MGMT_DATA_I,
              SERIAL_MGMT_CLOCK_I}),
    .sync_o(pins_sync)
  );

  wire s_clk = pins_sync[0];
  wire s_dat = pins_sync[1];
  wire s_sel_n = pins_sync[2];
  wire [1:0] s_strap = pins_sync[4:3];

  // Frame state.
  scsa_state_type state;
  logic clk_prev;
  logic [5:0] ones;
  logic [5:0] bitcnt;
  logic [9:0] hdr;
  logic [1:0] opcode;
  logic tsel;
  logic [6:0] addr;
  logic [31:0] shreg;

  // Status registers.
  logic [31:0] cable_fault_status;
  logic [31:0] receive_counter_overflow_flags;
  logic [31:0] transmit_counter_overflow_flags;
  logic [31:0] collision_error_overflow_flags;

  // Serial clock edges; data is sampled on the rise and driven on the fall.
  wire rise = s_clk & ~clk_prev;
  wire fall = ~s_clk & clk_prev; // [R19]
  wire [9:0] next_hdr = {hdr[8:0], s_dat};
  wire op_read = next_hdr[1:0] == `SCSA_OP_READ; // [R2]
  wire op_clear = next_hdr[1:0] == `SCSA_OP_CLEAR; // [R11]
  wire hdr_done = (opcode == `SCSA_OP_READ) ? (bitcnt == `SCSA_RD_HDR_LAST)
                                            : (bitcnt == `SCSA_CLR_HDR_LAST);
  wire clr_hit = next_hdr[9:8] == s_strap; // [R12]
  wire clr_fire = rise && state == ST_HDR && hdr_done && opcode == `SCSA_OP_CLEAR && clr_hit;

  // Counter-table word: the four local registers overlay the external store.
  wire [31:0] cnt_word = (addr == `SCSA_OFS_CABLE) ? cable_fault_status :
                         (addr == `SCSA_OFS_RX_OVF) ? receive_counter_overflow_flags :
                         (addr == `SCSA_OFS_TX_OVF) ? transmit_counter_overflow_flags :
                         (addr == `SCSA_OFS_CE_OVF) ? collision_error_overflow_flags :
                         CNT_RD_DATA_I;
  // EEPROM word: odd register of the pair in the high half, sent first.
  wire [31:0] ee_word = {EE_HI_DATA_I, EE_LO_DATA_I}; // [R7]
  wire [31:0] rd_word = tsel ? cnt_word : ee_word; // [R3]

  // Cable status: plain mirror of the port logic, reserved bits zero.
  logic [31:0] next_cable;
  always_comb begin
    next_cable = `SCSA_REG_RESET; // [R21]
    for (int p = 0; p < 5; p++) begin
      next_cable[cab_base(p) +: 2] = CABLE_FAULT_LEN_I[2*p +: 2]; // [R15]
      next_cable[cab_base(p) + `SCSA_CAB_FLAG_OFS] = CABLE_BROKEN_I[p]; // [R15]
    end
  end

  // Overflow flags: an event in the cycle of a port clear keeps its flag set.
  wire [31:0] clr_mask = (clr_fire && next_hdr[7]) ? port_mask(next_hdr[6:0]) : '0;
  wire [31:0] next_rx = (receive_counter_overflow_flags & ~clr_mask) |
                        ovf_set(OVF_EVENT_I.rx_pkt, OVF_EVENT_I.rx_byte); // [R16]
  wire [31:0] next_tx = (transmit_counter_overflow_flags & ~clr_mask) |
                        ovf_set(OVF_EVENT_I.tx_pkt, OVF_EVENT_I.tx_byte); // [R17]
  wire [31:0] next_ce = (collision_error_overflow_flags & ~clr_mask) |
                        ovf_set(OVF_EVENT_I.col, OVF_EVENT_I.err); // [R18]

  // Status register update.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      cable_fault_status <= `SCSA_REG_RESET; // [R21]
      receive_counter_overflow_flags <= `SCSA_REG_RESET;
      transmit_counter_overflow_flags <= `SCSA_REG_RESET;
      collision_error_overflow_flags <= `SCSA_REG_RESET;
    end else begin
      cable_fault_status <= next_cable;
      receive_counter_overflow_flags <= next_rx;
      transmit_counter_overflow_flags <= next_tx;
      collision_error_overflow_flags <= next_ce;
    end
  end

  // Clear request pulses, one CLK_I cycle each.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      CLEAR_O <= '0;
    end else begin
      CLEAR_O.port <= clr_fire & next_hdr[7]; // [R13]
      CLEAR_O.counter <= clr_fire & ~next_hdr[7]; // [R13]
      if (clr_fire) begin
        CLEAR_O.index <= next_hdr[6:0]; // [R14]
      end
    end
  end

  // Frame decoder and serial answer. Deasserting select aborts any frame except a clear whose last header rise
  // lands in the same cycle, and releases the data line at once, so a host that gives up never collides.
  always_ff @(posedge CLK_I) begin
    if (RESET_I || s_sel_n) begin // [R10]
      state <= ST_PRE;
      clk_prev <= s_clk & ~RESET_I;
      ones <= '0;
      bitcnt <= '0;
      hdr <= '0;
      opcode <= '0;
      SERIAL_MGMT_DATA_OE_O <= 1'b0;
      SERIAL_MGMT_DATA_O <= 1'b0;
      if (RESET_I) begin
        tsel <= 1'b0;
        addr <= '0;
        shreg <= '0;
        CNT_RD_ADDR_O <= '0;
        EE_HI_ADDR_O <= '0;
        EE_LO_ADDR_O <= '0;
      end
    end else begin
      clk_prev <= s_clk;
      unique case (state)
        ST_PRE: if (rise) begin
          if (s_dat) begin
            ones <= (ones == `SCSA_PRE_MIN) ? ones : ones + 6'h01;
          end else if (ones == `SCSA_PRE_MIN) begin
            state <= ST_START; // [R1]
          end else begin
            ones <= '0;
          end
        end
        ST_START: if (rise) begin
          ones <= '0;
          bitcnt <= '0;
          hdr <= '0;
          state <= s_dat ? ST_OP : ST_PRE; // [R1]
        end
        ST_OP: if (rise) begin
          hdr <= next_hdr;
          bitcnt <= bitcnt + 6'h01;
          if (bitcnt == `SCSA_OP_LAST) begin
            opcode <= next_hdr[1:0];
            bitcnt <= '0;
            state <= (op_read || op_clear) ? ST_HDR : ST_PRE;
          end
        end
        ST_HDR: if (rise) begin
          hdr <= next_hdr;
          bitcnt <= bitcnt + 6'h01;
          if (hdr_done) begin
            bitcnt <= '0;
            if (opcode == `SCSA_OP_READ) begin
              tsel <= next_hdr[7]; // [R3]
              addr <= next_hdr[6:0]; // [R4]
              CNT_RD_ADDR_O <= next_hdr[6:0];
              EE_HI_ADDR_O <= next_hdr[6:0] | 7'h01; // [R8]
              EE_LO_ADDR_O <= next_hdr[6:0] & 7'h7e; // [R8]
              state <= ST_TA;
            end else begin
              state <= ST_PRE;
            end
          end
        end
        ST_TA: if (rise) begin
          bitcnt <= bitcnt + 6'h01;
          if (bitcnt == `SCSA_TA_LAST) begin
            bitcnt <= '0;
            state <= ST_DATA; // [R20]
          end
        end
        ST_DATA: if (fall) begin
          bitcnt <= bitcnt + 6'h01;
          if (bitcnt == '0) begin
            SERIAL_MGMT_DATA_O <= rd_word[31]; // [R6]
            shreg <= {rd_word[30:0], 1'b0};
            SERIAL_MGMT_DATA_OE_O <= 1'b1; // [R20]
          end else if (bitcnt == `SCSA_DATA_BITS) begin
            SERIAL_MGMT_DATA_OE_O <= 1'b0; // [R5]
            SERIAL_MGMT_DATA_O <= 1'b0;
            bitcnt <= '0;
            state <= ST_PRE;
          end else begin
            SERIAL_MGMT_DATA_O <= shreg[31]; // [R6]
            shreg <= {shreg[30:0], 1'b0};
          end
        end
      endcase
    end
  end

endmodule : scsa_top

/* sim/scsa_checker.sv */
/*
  Concurrent checks on the serial management pins and clear outputs.
  Assumes binding into scsa_top and a host whose serial clock is far slower than CLK_I.
*/
`timescale 1ns/1ps
module scsa_checker
  import scsa_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Watched pins and outputs.
  input wire logic SERIAL_MGMT_CLOCK_I,
  input wire logic SERIAL_MGMT_SELECT_N_I,
  input wire logic SERIAL_MGMT_DATA_O,
  input wire logic SERIAL_MGMT_DATA_OE_O,
  input wire scsa_clear_type CLEAR_O
);
  logic [8:0] oe_cnt;

  default clocking cb @(posedge CLK_I); endclocking

  // Counts driven cycles, so a short or long data phase shows at its end.
  always_ff @(posedge CLK_I) begin
    oe_cnt <= (RESET_I || !SERIAL_MGMT_DATA_OE_O) ? 9'h000 : oe_cnt + 9'h001;
  end

  a_reset_quiet: assert property (RESET_I |=> !SERIAL_MGMT_DATA_OE_O && CLEAR_O == '0)
    else $error("outputs not quiet after reset");
  a_oe_span: assert property (disable iff (RESET_I)
    $fell(SERIAL_MGMT_DATA_OE_O) && !SERIAL_MGMT_SELECT_N_I |-> oe_cnt inside {[254:258]})
    else $error("data phase is not 32 serial periods");
  a_idle_released: assert property (disable iff (RESET_I)
    SERIAL_MGMT_SELECT_N_I [*5] |-> !SERIAL_MGMT_DATA_OE_O)
    else $error("line driven while not selected");
  a_drive_after_fall: assert property (disable iff (RESET_I)
    $rose(SERIAL_MGMT_DATA_OE_O) |-> !$past(SERIAL_MGMT_CLOCK_I) && !SERIAL_MGMT_SELECT_N_I)
    else $error("drive started outside a low serial phase");
  a_data_on_fall: assert property (disable iff (RESET_I)
    $changed(SERIAL_MGMT_DATA_O) |-> !$past(SERIAL_MGMT_CLOCK_I, 2))
    else $error("data changed while serial clock high");
  a_clear_exclusive: assert property (disable iff (RESET_I)
    !(CLEAR_O.port && CLEAR_O.counter))
    else $error("both clear kinds at once");
  a_clear_single: assert property (disable iff (RESET_I)
    CLEAR_O.port || CLEAR_O.counter |=> !CLEAR_O.port && !CLEAR_O.counter)
    else $error("clear pulse longer than one cycle");
  a_clear_on_rise: assert property (disable iff (RESET_I)
    CLEAR_O.port || CLEAR_O.counter |-> $past(SERIAL_MGMT_CLOCK_I, 3) && !SERIAL_MGMT_SELECT_N_I)
    else $error("clear pulse not tied to a serial rise");
  a_index_hold: assert property (disable iff (RESET_I)
    !CLEAR_O.port && !CLEAR_O.counter |-> $stable(CLEAR_O.index))
    else $error("clear index moved without a clear");
endmodule : scsa_checker

bind scsa_top scsa_checker chk (
  .CLK_I(CLK_I),
  .RESET_I(RESET_I),
  .SERIAL_MGMT_CLOCK_I(SERIAL_MGMT_CLOCK_I),
  .SERIAL_MGMT_SELECT_N_I(SERIAL_MGMT_SELECT_N_I),
  .SERIAL_MGMT_DATA_O(SERIAL_MGMT_DATA_O),
  .SERIAL_MGMT_DATA_OE_O(SERIAL_MGMT_DATA_OE_O),
  .CLEAR_O(CLEAR_O)
);

/* sim/scsa_host.sv */
/*
  Host management controller model: clocks read and clear frames.
  Assumes clk_i is the system clock; all pin changes land on its falling edge.
*/
`timescale 1ns/1ps
module scsa_host (
  // Clock and resolved data line.
  input wire logic clk_i,
  input wire logic line_i,
  // Host pins.
  output logic sclk_o,
  output logic sel_n_o,
  output logic drv_o,
  output logic dat_o
);
  // Idle: clock stands low, not selected, line released.
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    drv_o = 1'b0;
    dat_o = 1'b0;
  end

  // One 800 ns serial period; the line is read just before the fall, when it is settled.
  task automatic tick(input logic d, input logic en, output logic r);
    drv_o = en;
    dat_o = d;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    r = line_i;
    sclk_o = 1'b0;
  endtask : tick

  // An 8-bit header, as a read uses, collects 32 bits; headers of other lengths collect nothing.
  task automatic frame(input logic [1:0] op, input logic [9:0] hdr, input int n,
                       output logic [31:0] rd);
    logic r;
    int i;
    rd = '0;
    @(negedge clk_i);
    sel_n_o = 1'b0;
    for (i = 0; i < 34; i++) tick(i != 32, 1'b1, r);
    for (i = 1; i >= 0; i--) tick(op[i], 1'b1, r);
    for (i = n - 1; i >= 0; i--) tick(hdr[i], 1'b1, r);
    if (n == 8) begin
      for (i = 0; i < 34; i++) begin
        tick(1'b1, 1'b0, r);
        rd = {rd[30:0], r};
      end
    end
    // Select stays low through the idle clock, so the device closes its data
    // phase at the last fall by itself instead of through an abort.
    tick(1'b1, 1'b0, r);
    // A deselected gap of several cycles lets the idle-release check see the line.
    sel_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask : frame
endmodule : scsa_host

/* sim/tb_top.sv */
/*
  Self-checking bench for scsa_top with a behavioural table model.
  Assumes scsa_host drives the serial pins and the line has a pull-up.
*/
`timescale 1ns/1ps
module tb_top;
  import scsa_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, sel_n, hdrv, hdat, dout, oe;
  logic [1:0] strap;
  logic [6:0] cnt_a, ee_ha, ee_la;
  logic [9:0] cab_len;
  logic [4:0] cab_brk;
  scsa_ovf_type ovf;
  scsa_clear_type clr;
  logic [31:0] cnt_mem [128];
  logic [15:0] ee_mem [128];
  logic [31:0] flg [3];
  logic [31:0] r;
  int opos [6] = '{0, 2, 4, 6, 7, 8};
  int cbase [5] = '{0, 6, 12, 18, 21};
  int seed = 32'hfb69;
  int fail_count, cmp_count, cyc, port_n, ctr_n, i;
  // Pull-up holds the line high whenever nobody drives it.
  wire line = oe ? dout : (hdrv ? hdat : 1'b1);
  wire [31:0] cnt_d = cnt_mem[cnt_a];

  scsa_top DUT (.CLK_I(clk), .RESET_I(rst), .SERIAL_MGMT_CLOCK_I(sclk),
    .SERIAL_MGMT_SELECT_N_I(sel_n), .SERIAL_MGMT_DATA_I(line), .SERIAL_MGMT_DATA_O(dout),
    .SERIAL_MGMT_DATA_OE_O(oe), .CHIP_PHYS_ADDR_STRAP_I(strap), .CNT_RD_ADDR_O(cnt_a),
    .CNT_RD_DATA_I(cnt_d), .EE_HI_ADDR_O(ee_ha), .EE_HI_DATA_I(ee_mem[ee_ha]),
    .EE_LO_ADDR_O(ee_la), .EE_LO_DATA_I(ee_mem[ee_la]), .CABLE_FAULT_LEN_I(cab_len),
    .CABLE_BROKEN_I(cab_brk), .OVF_EVENT_I(ovf), .CLEAR_O(clr));
  scsa_host host (.clk_i(clk), .line_i(line), .sclk_o(sclk), .sel_n_o(sel_n),
    .drv_o(hdrv), .dat_o(hdat));

  always #50 clk = ~clk;

  // Cycle ceiling and clear pulse counting.
  always @(posedge clk) begin
    cyc++;
    if (!rst && clr.port) port_n++;
    if (!rst && clr.counter) ctr_n++;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Word a read frame should return, built from the model tables.
  function automatic logic [31:0] exp_rd(input logic ts, input logic [6:0] a);
    logic [31:0] cab;
    cab = '0;
    for (int p = 0; p < 5; p++) cab[cbase[p] +: 3] = {cab_brk[p], cab_len[2 * p +: 2]};
    if (!ts) return a[0] ? {ee_mem[a], ee_mem[a - 7'h1]} : {ee_mem[a + 7'h1], ee_mem[a]};
    case (a)
      7'h03: return cab;
      7'h3a: return flg[0];
      7'h3b: return flg[1];
      7'h3c: return flg[2];
      default: return cnt_mem[a];
    endcase
  endfunction : exp_rd

  task automatic rd(input logic ts, input logic [6:0] a);
    host.frame(2'h2, {2'h0, ts, a}, 8, r);
    check(r, exp_rd(ts, a));
  endtask : rd

  // One-cycle overflow pulses; the model's flags are sticky.
  task automatic inject(input logic [35:0] v);
    @(negedge clk);
    ovf = v;
    for (int p = 0; p < 6; p++) begin
      flg[0][opos[p]] |= ovf.rx_pkt[p];
      flg[0][opos[p] + 9] |= ovf.rx_byte[p];
      flg[1][opos[p]] |= ovf.tx_pkt[p];
      flg[1][opos[p] + 9] |= ovf.tx_byte[p];
      flg[2][opos[p]] |= ovf.col[p];
      flg[2][opos[p] + 9] |= ovf.err[p];
    end
    @(negedge clk);
    ovf = '0;
  endtask : inject

  task automatic clr_frame(input logic [1:0] dev, input logic sc, input logic [6:0] idx);
    int pn;
    int cn;
    pn = port_n;
    cn = ctr_n;
    host.frame(2'h1, {dev, sc, idx}, 10, r);
    if (dev == strap && sc && idx < 7'h6) begin
      for (int k = 0; k < 3; k++) flg[k][opos[idx] +: 1] = 1'b0;
      for (int k = 0; k < 3; k++) flg[k][opos[idx] + 9] = 1'b0;
    end
    check(port_n - pn, (dev == strap && sc) ? 1 : 0);
    check(ctr_n - cn, (dev == strap && !sc) ? 1 : 0);
    if (dev == strap) check({25'h0, clr.index}, {25'h0, idx});
    for (int k = 0; k < 3; k++) rd(1'b1, 7'h3a + k[6:0]);
  endtask : clr_frame

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial begin
    strap = 2'($random(seed));
    cab_len = '0;
    cab_brk = '0;
    ovf = '0;
    flg = '{default: '0};
    for (i = 0; i < 128; i++) cnt_mem[i] = $random(seed);
    for (i = 0; i < 128; i++) ee_mem[i] = 16'($random(seed));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    rd(1'b1, 7'h03);
    for (i = 0; i < 3; i++) rd(1'b1, 7'h3a + i[6:0]);
    $display("test reset_values done");
    rd(1'b1, 7'h00);
    rd(1'b1, 7'h7f);
    rd(1'b1, 7'($random(seed)));
    $display("test counter_read done");
    rd(1'b0, 7'h00);
    rd(1'b0, 7'h03);
    rd(1'b0, 7'h7e);
    rd(1'b0, 7'h7f);
    $display("test eeprom_read done");
    host.frame(2'h3, 10'h085, 8, r);
    check(r, 32'hffffffff);
    $display("test bad_opcode done");
    cab_len = 10'($random(seed));
    cab_brk = 5'($random(seed));
    rd(1'b1, 7'h03);
    $display("test cable_status done");
    inject(36'($random(seed)));
    inject(36'hf_ffff_ffff);
    for (i = 0; i < 3; i++) rd(1'b1, 7'h3a + i[6:0]);
    $display("test overflow_flags done");
    clr_frame(strap, 1'b1, 7'h5);
    clr_frame(strap, 1'b1, 7'($random(seed) & 3));
    clr_frame(strap, 1'b0, 7'h2a);
    clr_frame(strap ^ 2'h1, 1'b1, 7'h0);
    $display("test clear_frames done");
    final_report();
  end
endmodule : tb_top
